// ### logic/mbs_frame_handler.sv
// slave frame handler: deframing, address filter, function decode, reply
// assumes a character receiver and transmitter outside, one clock domain
`timescale 1ns/10ps
`default_nettype none
`include "mbs_defs.svh"
// How it works
// - frequency source 0..4, default analog
// - run source 0..2, default terminals
// - secondary sources when input is 4, switch off
// - ascii frames colon, hex pairs, CR LF
// - at most sixteen data bytes
// - rtu frames bounded by ten ms idle
// - rtu: address, function, data, two-byte CRC
// - station zero broadcast, never answered
// - act only on own or broadcast address
// - decode read, write, loopback, multiple write
// - every register moves as two bytes
// - CRC mismatch discards the command
// - CRC starts at all ones
// - xor byte, eight shifts, poly on carry
// - every byte in order gives checksum
// - checksum sent low byte first
// - link reaches registers whatever the sources
// - own address latched once, zero ignores link
// - loss timer raises fault, zero disables
// - error reply sets function top bit
module mbs_frame_handler #(
  parameter int unsigned DEPTH = `MBS_MAX_DATA + `MBS_RTU_MIN,
  parameter int unsigned IDLE_CYC = `MBS_IDLE_MS * `MBS_CLK_KHZ,
  parameter int unsigned TICK_CYC = `MBS_TICK_MS * `MBS_CLK_KHZ,
  parameter int unsigned MAX_WORDS = `MBS_MAX_WORDS
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire mbs_pkg::mbs_byte_type rx_i,
  input wire logic tx_ready_i,
  output var mbs_pkg::mbs_byte_type tx_o,
  input wire logic [7:0] own_station_address_i,
  input wire logic [3:0] char_format_select_i,
  input wire logic [6:0] comm_loss_timeout_i,
  input wire logic [7:0][3:0] multi_input_function_sel_i,
  input wire logic src_switch_i,
  output var mbs_pkg::mbs_src_type src_o,
  output logic link_freq_o,
  output logic link_run_o,
  output logic comm_fault_o,
  output logic frame_drop_o
);
  import mbs_pkg::*;
  localparam int GW = $clog2(IDLE_CYC + 1);
  localparam int TW = $clog2(TICK_CYC + 1);
  localparam int PW = $clog2(DEPTH + 5);

  // the buffer must hold the longest frame and the longest read reply
  if (DEPTH < `MBS_MAX_DATA + `MBS_RTU_MIN || 2 * MAX_WORDS > `MBS_MAX_DATA || IDLE_CYC < 1)
    $error("mbs_frame_handler: unusable parameters");

  // one crc byte step
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `MBS_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction
  // hex character to nibble, top bit flags a bad character
  function automatic logic [4:0] hex2n(input logic [7:0] ch);
    if (ch >= `MBS_CH_0 && ch < `MBS_CH_A - 8'h07)
      return {1'b0, 4'(ch - `MBS_CH_0)};
    else if (ch >= `MBS_CH_A && ch <= `MBS_CH_F)
      return {1'b0, 4'(ch - `MBS_CH_AOFS)};
    else
      return 5'h10;
  endfunction
  function automatic logic [7:0] n2hex(input logic [3:0] n);
    return (n < `MBS_TEN) ? `MBS_CH_0 + {4'h0, n} : `MBS_CH_AOFS + {4'h0, n};
  endfunction
  // register map lookup: valid bit and bank index
  function automatic logic [2:0] reg_map(input logic [15:0] a);
    case (a)
      `MBS_A_FREQ1: return 3'h4;
      `MBS_A_RUN1: return 3'h5;
      `MBS_A_FREQ2: return 3'h6;
      `MBS_A_RUN2: return 3'h7;
      default: return 3'h0;
    endcase
  endfunction

  // frame engine state
  mbs_state_type st_ff, nxt_st;
  logic [7:0] mem [DEPTH]; // frame and reply buffer
  logic mem_we;
  logic [PW-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic [PW-1:0] cnt_ff, nxt_cnt, j_ff, nxt_j, tlen_ff, nxt_tlen, tpos_ff, nxt_tpos, pi;
  logic [15:0] rcrc_ff, nxt_rcrc, tcrc_ff, nxt_tcrc, start_ff, nxt_start, qty_ff, nxt_qty;
  logic [7:0] rlrc_ff, nxt_rlrc, tlrc_ff, nxt_tlrc, fn_ff, nxt_fn, err_ff, nxt_err;
  logic [7:0] td_ff, nxt_td, own_ff, nxt_own, pb, tb, bv;
  logic [3:0] hi_ff, nxt_hi;
  logic [4:0] hx;
  logic [GW-1:0] gap_ff, nxt_gap;
  logic bad_ff, nxt_bad, nib_ff, nxt_nib, infr_ff, nxt_infr, bcast_ff, nxt_bcast;
  logic tnib_ff, nxt_tnib, tv_ff, nxt_tv, ascii_ff, nxt_ascii, cap_ff, nxt_cap;
  logic valid_ff, nxt_valid, drop_ff, nxt_drop, good, hit, bok;
  logic [2:0] rm;
  logic [15:0] wv, lim;
  // register bank write port
  logic reg_we;
  logic [1:0] reg_wi;
  logic [15:0] reg_wd;
  logic [3:0][15:0] regs_ff, nxt_regs;

  // reply byte, with error and byte count fields patched in on the fly
  always_comb begin
    pi = ascii_ff ? tpos_ff - PW'(1) : tpos_ff;
    if (err_ff != 8'h00 && pi == PW'(`MBS_I_FN))
      pb = fn_ff | `MBS_ERR_BIT;
    else if (err_ff != 8'h00 && pi == PW'(`MBS_I_CNT))
      pb = err_ff;
    else if (fn_ff == `MBS_FN_RD && pi == PW'(`MBS_I_CNT))
      pb = {qty_ff[6:0], 1'b0};
    else
      pb = mem[pi];
  end

  // receive, parse, execute and transmit in one sequencer
  always_comb begin
    nxt_st = st_ff; nxt_cnt = cnt_ff; nxt_j = j_ff; nxt_tlen = tlen_ff;
    nxt_tpos = tpos_ff; nxt_rcrc = rcrc_ff; nxt_tcrc = tcrc_ff;
    nxt_start = start_ff; nxt_qty = qty_ff; nxt_rlrc = rlrc_ff;
    nxt_tlrc = tlrc_ff; nxt_fn = fn_ff; nxt_err = err_ff; nxt_td = td_ff;
    nxt_own = own_ff; nxt_hi = hi_ff; nxt_bad = bad_ff; nxt_nib = nib_ff;
    nxt_infr = infr_ff; nxt_bcast = bcast_ff; nxt_tnib = tnib_ff;
    nxt_tv = tv_ff; nxt_ascii = ascii_ff; nxt_cap = cap_ff;
    nxt_valid = 1'b0; nxt_drop = 1'b0;
    mem_we = 1'b0; mem_wa = cnt_ff; mem_wd = rx_i.data;
    reg_we = 1'b0; reg_wi = 2'h0; reg_wd = qty_ff;
    bok = 1'b0; bv = rx_i.data; hx = hex2n(rx_i.data); tb = pb;
    good = 1'b0; hit = 1'b0; rm = 3'h0; wv = 16'h0000; lim = 16'h0000;
    // idle gap since last character, saturating
    nxt_gap = rx_i.valid ? '0 : (gap_ff == GW'(IDLE_CYC) ? gap_ff : gap_ff + GW'(1));
    // address and framing take effect only at start-up
    if (!cap_ff) begin
      nxt_own = own_station_address_i;
      nxt_ascii = char_format_select_i >= `MBS_FMT_ASCII;
      nxt_cap = 1'b1;
    end
    case (st_ff)
      ST_RX: begin
        if (ascii_ff) begin
          if (!rx_i.valid) begin
            // nothing arrived
          end else if (rx_i.data == `MBS_COLON) begin
            nxt_cnt = '0; nxt_rcrc = `MBS_CRC_INIT; nxt_rlrc = 8'h00;
            nxt_bad = 1'b0; nxt_nib = 1'b0; nxt_infr = 1'b1;
          end else if (infr_ff && rx_i.data == `MBS_LF) begin
            nxt_infr = 1'b0; nxt_st = ST_PARSE;
          end else if (infr_ff && rx_i.data != `MBS_CR) begin
            if (hx[4]) nxt_bad = 1'b1;
            else if (nib_ff) begin
              bok = 1'b1; bv = {hi_ff, hx[3:0]}; nxt_nib = 1'b0;
            end else begin
              nxt_hi = hx[3:0]; nxt_nib = 1'b1;
            end
          end
        end else if (rx_i.valid) begin
          bok = 1'b1;
        end else if (gap_ff == GW'(IDLE_CYC) && cnt_ff != '0) begin
          nxt_st = ST_PARSE;
        end
        // append a byte; an overlong frame is poisoned, not wrapped
        if (bok) begin
          if (cnt_ff == PW'(DEPTH)) nxt_bad = 1'b1;
          else begin
            mem_we = 1'b1; mem_wd = bv; nxt_cnt = cnt_ff + PW'(1);
            nxt_rcrc = crc_step(rcrc_ff, bv);
            nxt_rlrc = rlrc_ff + bv;
          end
        end
      end
      ST_PARSE: begin
        // crc over a frame with its own crc leaves zero, lrc sums to zero
        good = !bad_ff && (ascii_ff ?
               (cnt_ff >= PW'(`MBS_ASC_MIN) && rlrc_ff == 8'h00) :
               (cnt_ff >= PW'(`MBS_RTU_MIN) && rcrc_ff == 16'h0000));
        hit = own_ff != `MBS_BCAST && own_ff <= `MBS_MAX_STN &&
              (mem[0] == own_ff || mem[0] == `MBS_BCAST);
        nxt_tlen = cnt_ff - PW'(ascii_ff ? `MBS_LRC_LEN : `MBS_CRC_LEN);
        nxt_fn = mem[`MBS_I_FN];
        nxt_start = {mem[`MBS_I_CNT], mem[`MBS_I_CNT+1]};
        nxt_qty = {mem[`MBS_I_CNT+2], mem[`MBS_I_CNT+3]};
        nxt_bcast = mem[0] == `MBS_BCAST;
        nxt_err = 8'h00; nxt_j = '0; nxt_tpos = '0; nxt_tnib = 1'b0;
        nxt_tcrc = `MBS_CRC_INIT; nxt_tlrc = 8'h00;
        nxt_cnt = '0; nxt_rcrc = `MBS_CRC_INIT; nxt_rlrc = 8'h00;
        nxt_bad = 1'b0; nxt_nib = 1'b0;
        nxt_valid = good && hit;
        nxt_drop = !good;
        nxt_st = (good && hit) ? ST_EXEC : ST_RX;
      end
      ST_EXEC: begin
        nxt_st = ST_TX;
        case (fn_ff)
          `MBS_FN_LOOP: ;
          `MBS_FN_WR1: begin
            rm = reg_map(start_ff);
            lim = rm[0] ? `MBS_MAX_RUN : `MBS_MAX_FREQ;
            if (tlen_ff != PW'(`MBS_HDR_LEN)) nxt_err = `MBS_EC_DATA;
            else if (!rm[2]) nxt_err = `MBS_EC_ADDR;
            else if (qty_ff > lim) nxt_err = `MBS_EC_DATA;
            else begin
              reg_we = 1'b1; reg_wi = rm[1:0];
            end
          end
          `MBS_FN_RD: begin
            rm = reg_map(start_ff + 16'(j_ff >> 1));
            if (tlen_ff != PW'(`MBS_HDR_LEN) || qty_ff == 16'h0000 || qty_ff > 16'(MAX_WORDS))
              nxt_err = `MBS_EC_DATA;
            else if (!rm[2]) nxt_err = `MBS_EC_ADDR;
            else begin
              // one reply byte per cycle, high byte first
              mem_we = 1'b1; mem_wa = PW'(`MBS_RD_DATA) + j_ff;
              mem_wd = j_ff[0] ? regs_ff[rm[1:0]][7:0] : regs_ff[rm[1:0]][15:8];
              nxt_j = j_ff + PW'(1);
              if (16'(j_ff) + 16'h0001 == {qty_ff[14:0], 1'b0})
                nxt_tlen = PW'(`MBS_RD_DATA) + PW'({qty_ff[6:0], 1'b0});
              else nxt_st = ST_EXEC;
            end
          end
          `MBS_FN_WRN: begin
            rm = reg_map(start_ff + 16'(j_ff));
            lim = rm[0] ? `MBS_MAX_RUN : `MBS_MAX_FREQ;
            wv = {mem[PW'(`MBS_WRN_DATA) + {j_ff[PW-2:0], 1'b0}],
                  mem[PW'(`MBS_WRN_DATA + 1) + {j_ff[PW-2:0], 1'b0}]};
            if (qty_ff == 16'h0000 || qty_ff > 16'(MAX_WORDS) ||
                16'(tlen_ff) != 16'(`MBS_WRN_DATA) + {qty_ff[14:0], 1'b0})
              nxt_err = `MBS_EC_DATA;
            else if (!rm[2]) nxt_err = `MBS_EC_ADDR;
            else if (wv > lim) nxt_err = `MBS_EC_DATA;
            else begin
              reg_we = 1'b1; reg_wi = rm[1:0]; reg_wd = wv;
              nxt_j = j_ff + PW'(1);
              if (16'(j_ff) + 16'h0001 == qty_ff) nxt_tlen = PW'(`MBS_HDR_LEN);
              else nxt_st = ST_EXEC;
            end
          end
          default: nxt_err = `MBS_EC_FUNC;
        endcase
        if (nxt_err != 8'h00) nxt_tlen = PW'(`MBS_ERR_LEN);
        // broadcasts are executed silently
        if (nxt_st == ST_TX && bcast_ff) nxt_st = ST_RX;
      end
      ST_TX: begin
        // a character waiting on the transmitter is held still
        if (!tv_ff || tx_ready_i) begin
          nxt_tv = 1'b1;
          if (ascii_ff) begin
            if (tpos_ff == '0) begin
              nxt_td = `MBS_COLON; nxt_tpos = PW'(1);
            end else if (tpos_ff <= tlen_ff + PW'(1)) begin
              if (tpos_ff == tlen_ff + PW'(1)) tb = 8'h00 - tlrc_ff;
              nxt_td = n2hex(tnib_ff ? tb[3:0] : tb[7:4]);
              nxt_tnib = !tnib_ff;
              if (tnib_ff) nxt_tpos = tpos_ff + PW'(1);
              else if (tpos_ff <= tlen_ff) nxt_tlrc = tlrc_ff + pb;
            end else if (tpos_ff == tlen_ff + PW'(`MBS_P_CR)) begin
              nxt_td = `MBS_CR; nxt_tpos = tpos_ff + PW'(1);
            end else if (tpos_ff == tlen_ff + PW'(`MBS_P_LF)) begin
              nxt_td = `MBS_LF; nxt_tpos = tpos_ff + PW'(1);
            end else begin
              nxt_tv = 1'b0; nxt_st = ST_RX;
            end
          end else if (tpos_ff < tlen_ff) begin
            nxt_td = pb; nxt_tcrc = crc_step(tcrc_ff, pb);
            nxt_tpos = tpos_ff + PW'(1);
          end else if (tpos_ff == tlen_ff) begin
            nxt_td = tcrc_ff[7:0]; nxt_tpos = tpos_ff + PW'(1);
          end else if (tpos_ff == tlen_ff + PW'(1)) begin
            nxt_td = tcrc_ff[15:8]; nxt_tpos = tpos_ff + PW'(1);
          end else begin
            nxt_tv = 1'b0; nxt_st = ST_RX;
          end
        end
      end
      default: nxt_st = ST_RX;
    endcase
  end

  // sequencer registers; the buffer itself needs no reset
  always_ff @(posedge clk_i) begin
    if (mem_we) mem[mem_wa] <= mem_wd;
    if (!rst_n_i) begin
      st_ff <= ST_RX; cnt_ff <= '0; j_ff <= '0; tlen_ff <= '0; tpos_ff <= '0;
      rcrc_ff <= `MBS_CRC_INIT; tcrc_ff <= `MBS_CRC_INIT; start_ff <= 16'h0000;
      qty_ff <= 16'h0000; rlrc_ff <= 8'h00; tlrc_ff <= 8'h00; fn_ff <= 8'h00;
      err_ff <= 8'h00; td_ff <= 8'h00; own_ff <= 8'h00; hi_ff <= 4'h0;
      gap_ff <= '0; bad_ff <= 1'b0; nib_ff <= 1'b0; infr_ff <= 1'b0;
      bcast_ff <= 1'b0; tnib_ff <= 1'b0; tv_ff <= 1'b0; ascii_ff <= 1'b0;
      cap_ff <= 1'b0; valid_ff <= 1'b0; drop_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st; cnt_ff <= nxt_cnt; j_ff <= nxt_j; tlen_ff <= nxt_tlen;
      tpos_ff <= nxt_tpos; rcrc_ff <= nxt_rcrc; tcrc_ff <= nxt_tcrc;
      start_ff <= nxt_start; qty_ff <= nxt_qty; rlrc_ff <= nxt_rlrc;
      tlrc_ff <= nxt_tlrc; fn_ff <= nxt_fn; err_ff <= nxt_err; td_ff <= nxt_td;
      own_ff <= nxt_own; hi_ff <= nxt_hi; gap_ff <= nxt_gap; bad_ff <= nxt_bad;
      nib_ff <= nxt_nib; infr_ff <= nxt_infr; bcast_ff <= nxt_bcast;
      tnib_ff <= nxt_tnib; tv_ff <= nxt_tv; ascii_ff <= nxt_ascii;
      cap_ff <= nxt_cap; valid_ff <= nxt_valid; drop_ff <= nxt_drop;
    end
  end

  // source selector bank, written only over the link
  always_comb begin
    nxt_regs = regs_ff;
    if (reg_we) nxt_regs[reg_wi] = reg_wd;
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) regs_ff <= {`MBS_RST_SEC, `MBS_RST_SEC, `MBS_RST_PRI, `MBS_RST_PRI};
    else regs_ff <= nxt_regs;
  end

  // any of the multi-function inputs may ask for the secondary set
  logic [7:0] mif_hit;
  for (genvar g = 0; g < 8; g++) begin : g_mif
    assign mif_hit[g] = multi_input_function_sel_i[g] == `MBS_MIF_SEL2;
  end
  logic sec_on;
  mbs_src_type src_ff, nxt_src;
  logic lf_ff, nxt_lf, lr_ff, nxt_lr;
  always_comb begin
    sec_on = |mif_hit && !src_switch_i;
    nxt_src.freq = sec_on ? regs_ff[2][2:0] : regs_ff[0][2:0];
    nxt_src.run = sec_on ? regs_ff[3][1:0] : regs_ff[1][1:0];
    nxt_lf = nxt_src.freq == `MBS_FREQ_LINK;
    nxt_lr = nxt_src.run == `MBS_RUN_LINK;
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      // reset shows the primary defaults, not keypad, so nothing sees a false source
      src_ff <= '{freq: 3'(`MBS_RST_PRI), run: 2'(`MBS_RST_PRI)};
      lf_ff <= 1'b0;
      lr_ff <= 1'b0;
    end else begin
      src_ff <= nxt_src; lf_ff <= nxt_lf; lr_ff <= nxt_lr;
    end
  end

  // loss timer in tenths of a second; a good frame to this station or broadcast restarts it
  logic [TW-1:0] tick_ff, nxt_tick;
  logic [6:0] deci_ff, nxt_deci;
  logic fault_ff, nxt_fault;
  always_comb begin
    nxt_tick = (tick_ff == TW'(TICK_CYC - 1)) ? '0 : tick_ff + TW'(1);
    nxt_deci = deci_ff + 7'((tick_ff == TW'(TICK_CYC - 1)) && !(&deci_ff));
    nxt_fault = fault_ff;
    if (valid_ff) begin
      nxt_tick = '0; nxt_deci = 7'h00; nxt_fault = 1'b0;
    end
    if (comm_loss_timeout_i == 7'h00) nxt_fault = 1'b0;
    else if (deci_ff >= comm_loss_timeout_i) nxt_fault = 1'b1;
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tick_ff <= '0; deci_ff <= 7'h00; fault_ff <= 1'b0;
    end else begin
      tick_ff <= nxt_tick; deci_ff <= nxt_deci; fault_ff <= nxt_fault;
    end
  end

  assign tx_o = '{valid: tv_ff, data: td_ff};
  assign src_o = src_ff;
  assign link_freq_o = lf_ff;
  assign link_run_o = lr_ff;
  assign comm_fault_o = fault_ff;
  assign frame_drop_o = drop_ff;

  // checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_ascii_colon: assert property (
    tv_ff && ascii_ff && tpos_ff == PW'(1) && !tnib_ff |-> td_ff == `MBS_COLON)
    else $error("ascii reply does not open with colon");
  a_ascii_tail: assert property (
    tv_ff && ascii_ff && tpos_ff == tlen_ff + PW'(`MBS_P_LF) + PW'(1) |-> td_ff == `MBS_LF)
    else $error("ascii reply does not end with LF");
  a_bcast_quiet: assert property (st_ff == ST_TX |-> !bcast_ff)
    else $error("reply sent to broadcast");
  a_crc_discard: assert property (
    st_ff == ST_PARSE && !ascii_ff && rcrc_ff != 16'h0000 |=> st_ff == ST_RX)
    else $error("frame with bad crc executed");
  a_crc_seed: assert property (st_ff == ST_EXEC |-> tcrc_ff == `MBS_CRC_INIT)
    else $error("reply crc not seeded");
  a_crc_low_first: assert property (
    tv_ff && !ascii_ff && tpos_ff > tlen_ff |->
    td_ff == ((tpos_ff == tlen_ff + PW'(1)) ? tcrc_ff[7:0] : tcrc_ff[15:8]))
    else $error("crc bytes out of order");
  a_err_fn_bit: assert property (
    tv_ff && !ascii_ff && err_ff != 8'h00 && tpos_ff == PW'(`MBS_I_CNT) |->
    td_ff == (fn_ff | `MBS_ERR_BIT))
    else $error("error reply lacks top function bit");
  a_fault_gate: assert property ($rose(fault_ff) |-> $past(comm_loss_timeout_i) != 7'h00)
    else $error("loss fault while timer disabled");
  a_sec_select: assert property (
    sec_on |=> src_o.freq == $past(regs_ff[2][2:0]) && src_o.run == $past(regs_ff[3][1:0]))
    else $error("secondary sources not applied");
  a_own_zero: assert property (st_ff == ST_EXEC |-> own_ff != `MBS_BCAST)
    else $error("station zero acted on a frame");
  c_bcast_exec: cover property (st_ff == ST_EXEC && bcast_ff);
  c_err_reply: cover property (st_ff == ST_TX && err_ff != 8'h00);
  c_ascii_reply: cover property (tv_ff && ascii_ff && td_ff == `MBS_LF);
  c_multi_write: cover property (reg_we && fn_ff == `MBS_FN_WRN && j_ff != '0);
endmodule
`default_nettype wire

// ### logic/mbs_defs.svh
// constants of the serial link frame handler: characters, codes, offsets
// assumes inclusion by bare name from the design file
`ifndef MBS_DEFS_SVH
`define MBS_DEFS_SVH
`define MBS_COLON 8'h3a
`define MBS_CR 8'h0d
`define MBS_LF 8'h0a
`define MBS_CH_0 8'h30
`define MBS_CH_A 8'h41
`define MBS_CH_F 8'h46
`define MBS_CH_AOFS 8'h37
`define MBS_TEN 4'ha
`define MBS_CRC_INIT 16'hffff
`define MBS_CRC_POLY 16'ha001
`define MBS_BCAST 8'h00
`define MBS_MAX_STN 8'h1f
`define MBS_FN_RD 8'h03
`define MBS_FN_WR1 8'h06
`define MBS_FN_LOOP 8'h08
`define MBS_FN_WRN 8'h10
`define MBS_ERR_BIT 8'h80
`define MBS_EC_FUNC 8'h01
`define MBS_EC_ADDR 8'h02
`define MBS_EC_DATA 8'h03
`define MBS_A_FREQ1 16'h0100
`define MBS_A_RUN1 16'h0101
`define MBS_A_FREQ2 16'h0107
`define MBS_A_RUN2 16'h0108
`define MBS_RST_PRI 16'h0001
`define MBS_RST_SEC 16'h0000
`define MBS_MAX_FREQ 16'h0004
`define MBS_MAX_RUN 16'h0002
`define MBS_FREQ_LINK 3'h3
`define MBS_RUN_LINK 2'h2
`define MBS_MIF_SEL2 4'h4
`define MBS_FMT_ASCII 4'h4
`define MBS_I_FN 1
`define MBS_I_CNT 2
`define MBS_HDR_LEN 6
`define MBS_RD_DATA 3
`define MBS_WRN_DATA 7
`define MBS_ERR_LEN 3
`define MBS_RTU_MIN 4
`define MBS_ASC_MIN 3
`define MBS_CRC_LEN 2
`define MBS_LRC_LEN 1
`define MBS_P_CR 2
`define MBS_P_LF 3
`define MBS_MAX_DATA 16
`define MBS_MAX_WORDS 8
`define MBS_CLK_KHZ 40000
`define MBS_IDLE_MS 10
`define MBS_TICK_MS 100
`endif

// ### logic/mbs_pkg.sv
// types shared by the frame handler and its bench
// assumes mbs_defs.svh sits on the include path
package mbs_pkg;
  // one character or byte with its strobe
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } mbs_byte_type;
  // selected command sources
  typedef struct packed {
    logic [2:0] freq;
    logic [1:0] run;
  } mbs_src_type;
  typedef enum logic [1:0] {ST_RX, ST_PARSE, ST_EXEC, ST_TX} mbs_state_type;
endpackage

// ### tb/mbs_master_model.sv
// stand-in for the link master: sends request frames, collects the reply
// assumes the bench drives stimulus on the falling clock edge
`timescale 1ns/10ps
`default_nettype none
module mbs_master_model
  import mbs_pkg::*;
(
  input wire logic clk_i,
  input wire logic slow_i,
  input wire mbs_pkg::mbs_byte_type tx_i,
  output var mbs_pkg::mbs_byte_type rx_o,
  output logic tx_ready_o
);
  logic [7:0] got[$]; // reply characters taken so far
  initial begin
    rx_o = '0;
    tx_ready_o = 1'b1;
  end
  // checksum over a byte list, first byte is the station
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
    end
    return c;
  endfunction
  // one frame; idle gap follows since nothing else is sent
  task automatic send(input logic [7:0] b[$], input logic bad);
    logic [15:0] c;
    c = crc16(b) ^ {16{bad}};
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    send_raw(b);
  endtask
  // characters exactly as given, each a one-cycle strobe then a released cycle
  task automatic send_raw(input logic [7:0] b[$]);
    got.delete();
    foreach (b[i]) begin
      @(negedge clk_i);
      rx_o <= {1'b1, b[i]};
      @(negedge clk_i);
      rx_o <= {1'b0, ~b[i]}; // released line does not keep the old byte
    end
  endtask
  // reply accepted only when its residue is zero
  function automatic logic reply_ok();
    return crc16(got) == 16'h0000;
  endfunction
  // stall every other cycle when asked to be slow
  always @(negedge clk_i) begin
    tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
  end
  // take a character at each accepting edge
  always @(posedge clk_i) begin
    if (tx_i.valid && tx_ready_o) begin
      got.push_back(tx_i.data);
    end
  end
endmodule
`default_nettype wire

// ### tb/mbs_frame_handler_bench.sv
// self-checking bench for the frame handler in rtu and ascii framing
// assumes the master model file is compiled before this one
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module mbs_frame_handler_bench;
  import mbs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic slow = 1'b0; // master stalls the reply
  logic tx_ready;
  logic [6:0] tmo = 7'h00; // loss time, 0 disables
  logic [7:0][3:0] mif = '0; // input functions
  logic sw = 1'b1; // selection switch on
  logic [3:0] fmt = 4'h0; // framing, latched after each reset
  logic [7:0] own = 8'h01; // own station, latched after each reset
  // ascii write of 3 to the primary frequency source, lrc f5; the reply echoes it
  logic [7:0] asc[$] = '{8'h3a, 8'h30, 8'h31, 8'h30, 8'h36, 8'h30, 8'h31, 8'h30, 8'h30,
    8'h30, 8'h30, 8'h30, 8'h33, 8'h46, 8'h35, 8'h0d, 8'h0a};
  logic lf, lr, cf, fd;
  int bad_count = 0;
  int samples_checked = 0;
  int drops = 0;
  mbs_byte_type rx, tx;
  mbs_src_type src;
  always #12.5 clk = ~clk;
  // count drop pulses
  always @(posedge clk) begin
    if (fd === 1'b1) drops++;
  end
  mbs_frame_handler #(.IDLE_CYC(20), .TICK_CYC(50)) i_mbs_frame_handler (
    .clk_i(clk), .rst_n_i(rst_n), .rx_i(rx), .tx_ready_i(tx_ready), .tx_o(tx),
    .own_station_address_i(own), .char_format_select_i(fmt),
    .comm_loss_timeout_i(tmo), .multi_input_function_sel_i(mif),
    .src_switch_i(sw), .src_o(src), .link_freq_o(lf), .link_run_o(lr),
    .comm_fault_o(cf), .frame_drop_o(fd));
  mbs_master_model i_mbs_master_model (
    .clk_i(clk), .slow_i(slow), .tx_i(tx), .rx_o(rx), .tx_ready_o(tx_ready));
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // send a request, compare the whole reply, crc appended to expectation
  task automatic xfer(input logic [7:0] q[$], input logic bad, input logic [7:0] e[$]);
    logic [15:0] c;
    c = i_mbs_master_model.crc16(e);
    if (e.size() > 0) begin
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
    end
    i_mbs_master_model.send(q, bad);
    expect_reply(e);
  endtask
  // wait for the reply to settle, then compare it character by character
  task automatic expect_reply(input logic [7:0] e[$]);
    for (int n = 0; n < 300 && i_mbs_master_model.got.size() < e.size(); n++) begin
      @(negedge clk);
    end
    repeat (60) @(negedge clk);
    `CHK(i_mbs_master_model.got.size(), e.size())
    foreach (e[i]) begin
      `CHK(i_mbs_master_model.got[i], e[i])
    end
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    final_report();
  end
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    `CHK(src, {3'h1, 2'h1})
    xfer('{8'h01, 8'h06, 8'h01, 8'h00, 8'h00, 8'h03}, 1'b0,
      '{8'h01, 8'h06, 8'h01, 8'h00, 8'h00, 8'h03});
    `CHK(src.freq, 3'h3)
    `CHK(lf, 1'b1)
    slow = 1'b1;
    xfer('{8'h01, 8'h03, 8'h01, 8'h00, 8'h00, 8'h01}, 1'b0,
      '{8'h01, 8'h03, 8'h02, 8'h00, 8'h03});
    `CHK(i_mbs_master_model.reply_ok(), 1'b1)
    slow = 1'b0;
    xfer('{8'h01, 8'h06, 8'h01, 8'h01, 8'h00, 8'h02}, 1'b1, '{});
    `CHK(drops, 1)
    `CHK(lr, 1'b0)
    xfer('{8'h02, 8'h06, 8'h01, 8'h01, 8'h00, 8'h02}, 1'b0, '{});
    `CHK(lr, 1'b0)
    xfer('{8'h00, 8'h06, 8'h01, 8'h01, 8'h00, 8'h02}, 1'b0, '{});
    `CHK(lr, 1'b1)
    xfer('{8'h01, 8'h05, 8'h00, 8'h00}, 1'b0, '{8'h01, 8'h85, 8'h01});
    xfer('{8'h01, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34}, 1'b0,
      '{8'h01, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34});
    xfer('{8'h01, 8'h10, 8'h01, 8'h07, 8'h00, 8'h02, 8'h04, 8'h00, 8'h02, 8'h00, 8'h01},
      1'b0, '{8'h01, 8'h10, 8'h01, 8'h07, 8'h00, 8'h02});
    `CHK(src, {3'h3, 2'h2})
    mif[3] = 4'h4;
    sw = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(src, {3'h2, 2'h1})
    `CHK(lr, 1'b0)
    sw = 1'b1;
    repeat (3) @(negedge clk);
    `CHK(src, {3'h3, 2'h2})
    `CHK(cf, 1'b0)
    tmo = 7'h01;
    repeat (60) @(negedge clk);
    `CHK(cf, 1'b1)
    tmo = 7'h00;
    repeat (3) @(negedge clk);
    `CHK(cf, 1'b0)
    rst_n = 1'b0; // second reset, now in ascii framing
    fmt = 4'h4;
    repeat (8) @(negedge clk);
    `CHK(src, {3'h1, 2'h1})
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    i_mbs_master_model.send_raw(asc);
    expect_reply(asc);
    `CHK(src.freq, 3'h3)
    rst_n = 1'b0; // third reset: station zero must ignore the link
    fmt = 4'h0;
    own = 8'h00;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    xfer('{8'h00, 8'h06, 8'h01, 8'h01, 8'h00, 8'h02}, 1'b0, '{});
    `CHK(lr, 1'b0)
    final_report();
  end
endmodule
`default_nettype wire
